// ==== hw/adc_conv_cal_sequencer.sv ====
// conversion and calibration sequencer with parallel result port
// assumes all pins asynchronous; sample_value comes from the sys_clk core
`timescale 1ns/10ps
`include "adc_seq_params.svh"

module adc_conv_cal_sequencer #(
	parameter logic [`CNT_W-1:0] CAL_FULL_LEN   = `CAL_FULL_CYCLES,
	parameter logic [`CNT_W-1:0] CAL_DAC_FS_LEN = `CAL_DAC_FS_CYCLES,
	parameter logic [`CNT_W-1:0] CAL_OFFSET_LEN = `CAL_OFFSET_CYCLES
)(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              master_clock_in,
	input  wire logic              conversion_trigger,
	input  wire logic              chip_select_n,
	input  wire logic              read_n,
	input  wire logic              write_n,
	input  wire logic              high_byte_select,
	input  wire logic [`CTRL_W-1:0] bus_data_in,
	input  wire logic [`CTRL_W-1:0] sample_value,
	output logic                   busy,
	output logic                   hold_sample,
	output logic      [`CTRL_W-1:0] bus_data_out,
	output logic                   bus_data_oe,
	output logic                   full_power_down,
	output logic                   partial_power_down
);

	// *************************************************
	// pin synchronisers
	// *************************************************
	logic [5:0]         pin_lvl;
	logic [5:0]         pin_rise;
	logic [5:0]         pin_fall;
	logic [`CTRL_W-1:0] data_s;

	// strobes idle high: starting there keeps a false write out after reset
	pin_sync #(.W(6), .IDLE_LVL(6'h1c)) u_ctl_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin     ({high_byte_select, write_n, read_n, chip_select_n,
			master_clock_in, conversion_trigger}),
		.level   (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	// data bus takes the same delay as the strobes
	pin_sync #(.W(`CTRL_W)) u_data_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin     (bus_data_in),
		.level   (data_s),
		.rise    (),
		.fall    ()
	);

	logic trig_rise;
	logic mclk_rise;
	logic mclk_fall;
	logic cs_low;
	logic rd_low;
	logic wr_rise;
	logic hb_lvl;

	assign trig_rise = pin_rise[0];
	assign mclk_rise = pin_rise[1];
	assign mclk_fall = pin_fall[1];
	assign cs_low    = ~pin_lvl[2];
	assign rd_low    = ~pin_lvl[3];
	assign wr_rise   = pin_rise[4];
	assign hb_lvl    = pin_lvl[5];

	// *************************************************
	// sequencer state
	// *************************************************
	adc_seq_pkg::seq_state_t state;
	adc_seq_pkg::seq_state_t next_state;
	adc_seq_pkg::cal_kind_t  kind;
	adc_seq_pkg::cal_kind_t  next_kind;
	logic [`CNT_W-1:0]       cnt;
	logic [`CNT_W-1:0]       next_cnt;
	logic [`CTRL_W-1:0]      ctrl;
	logic [`CTRL_W-1:0]      next_ctrl;
	logic [`CTRL_W-1:0]      result;
	logic [`CTRL_W-1:0]      next_result;
	logic                    loaded;
	logic                    next_loaded;
	logic                    cs_prev;
	logic [`CTRL_W-1:0]      next_bus_data_out;
	logic                    next_bus_data_oe;
	logic                    next_full_pd;
	logic                    next_partial_pd;
	logic                    wr_take;
	logic [1:0]              wr_cal;

	function automatic logic [`CNT_W-1:0] cal_len(input adc_seq_pkg::cal_kind_t k);
		case (k)
			adc_seq_pkg::cal_dac_fs: cal_len = CAL_DAC_FS_LEN;
			adc_seq_pkg::cal_offset: cal_len = CAL_OFFSET_LEN;
			default:                 cal_len = CAL_FULL_LEN;
		endcase
	endfunction : cal_len

	// cs sampled a cycle early: it may rise together with the write strobe
	assign wr_take = wr_rise & cs_prev;
	assign wr_cal  = data_s[`CTRL_CAL_SEL_LSB +: 2];

	always_comb
	begin
		next_state  = state;
		next_kind   = kind;
		next_cnt    = cnt;
		next_ctrl   = ctrl;
		next_result = result;
		next_loaded = loaded;
		if (wr_take)
		begin
			// start bit self-clears; writes while busy still store  [R11]
			if (hb_lvl)
				next_ctrl[11:8] = data_s[11:8];
			else
			begin
				next_ctrl[7:0] = data_s[7:0];
				next_ctrl[`CTRL_CAL_START_BIT] = 1'b0;
			end
		end
		case (state)
			adc_seq_pkg::st_idle:
			begin
				if (trig_rise)
				begin
					next_state  = adc_seq_pkg::st_conv; // [R1] [R3]
					next_cnt    = '0;
					next_loaded = 1'b0;
				end
				else if (wr_take && !hb_lvl && data_s[`CTRL_CAL_START_BIT]
					&& wr_cal != 2'b11)
				begin
					next_state = adc_seq_pkg::st_cal; // [R5]
					next_kind  = adc_seq_pkg::cal_kind_t'(wr_cal);
					next_cnt   = '0;
				end
			end
			adc_seq_pkg::st_conv:
			begin
				// result lands on the fall before the last rise  [R4]
				if (mclk_fall && cnt == `CONV_CYCLES - 17'd1)
				begin
					next_result = sample_value;
					next_loaded = 1'b1;
				end
				if (mclk_rise)
				begin
					if (cnt == `CONV_CYCLES - 17'd1)
						next_state = adc_seq_pkg::st_idle; // [R2]
					else
						next_cnt = cnt + 17'd1;
				end
			end
			adc_seq_pkg::st_cal:
			begin
				if (mclk_rise)
				begin
					if (cnt == cal_len(kind) - 17'd1)
						next_state = adc_seq_pkg::st_idle; // [R6] [R7] [R8]
					else
						next_cnt = cnt + 17'd1;
				end
			end
			default: next_state = adc_seq_pkg::st_idle;
		endcase
		// byte follows select level, no read strobe needed  [R9]
		next_bus_data_out[11:8] = result[11:8];
		next_bus_data_out[7:0]  = hb_lvl ? {4'h0, result[11:8]} : result[7:0];
		next_bus_data_oe        = cs_low & rd_low;
		// sleep only when idle; clock must keep running to wake  [R10]
		next_full_pd    = (state == adc_seq_pkg::st_idle)
			& ctrl[`CTRL_PWR_HIGH_BIT] & ~ctrl[`CTRL_PWR_LOW_BIT];
		next_partial_pd = (state == adc_seq_pkg::st_idle)
			& ctrl[`CTRL_PWR_HIGH_BIT] & ctrl[`CTRL_PWR_LOW_BIT];
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state              <= adc_seq_pkg::st_idle;
			kind               <= adc_seq_pkg::cal_full;
			cnt                <= '0;
			ctrl               <= `CTRL_RESET;
			result             <= `RESULT_RESET;
			loaded             <= 1'b0;
			cs_prev            <= 1'b0;
			bus_data_out       <= `RESULT_RESET;
			bus_data_oe        <= 1'b0;
			full_power_down    <= 1'b0;
			partial_power_down <= 1'b0;
		end
		else
		begin
			state              <= next_state;
			kind               <= next_kind;
			cnt                <= next_cnt;
			ctrl               <= next_ctrl;
			result             <= next_result;
			loaded             <= next_loaded;
			cs_prev            <= cs_low;
			bus_data_out       <= next_bus_data_out;
			bus_data_oe        <= next_bus_data_oe;
			full_power_down    <= next_full_pd;
			partial_power_down <= next_partial_pd;
		end
	end

	assign busy        = (state != adc_seq_pkg::st_idle);
	assign hold_sample = (state == adc_seq_pkg::st_conv);

	// *************************************************
	// checks: independent count of master rises while busy
	// *************************************************
	logic [`CNT_W-1:0] chk_rises;
	logic              chk_conv;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			chk_rises <= '0;
			chk_conv  <= 1'b0;
		end
		else
		begin
			chk_rises <= !busy ? '0 : chk_rises + {16'h0000, mclk_rise};
			chk_conv  <= hold_sample;
		end
	end

	property p_trigger_hold;
		@(posedge sys_clk) disable iff (rst)
		trig_rise && !busy |=> hold_sample && busy;
	endproperty
	a_trigger_hold: assert property (p_trigger_hold) else $error("no hold on trigger"); // [R1]

	property p_conv_len;
		@(posedge sys_clk) disable iff (rst)
		$fell(busy) && chk_conv |-> chk_rises == `CONV_CYCLES;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // [R2]

	property p_busy_holds;
		@(posedge sys_clk) disable iff (rst)
		hold_sample && !mclk_rise |=> busy;
	endproperty
	a_busy_holds: assert property (p_busy_holds) else $error("busy dropped early"); // [R3]

	property p_result_first;
		@(posedge sys_clk) disable iff (rst)
		$fell(busy) && chk_conv |-> $past(loaded, 2);
	endproperty
	a_result_first: assert property (p_result_first) else $error("result late"); // [R4]

	property p_cal_busy;
		@(posedge sys_clk) disable iff (rst)
		wr_take && !busy && !trig_rise && !hb_lvl && data_s[`CTRL_CAL_START_BIT]
			&& wr_cal != 2'b11 |-> ##1 busy [*2];
	endproperty
	a_cal_busy: assert property (p_cal_busy) else $error("calibration busy late"); // [R5]

	property p_cal_len(adc_seq_pkg::cal_kind_t k, logic [`CNT_W-1:0] n);
		@(posedge sys_clk) disable iff (rst)
		$fell(busy) && !chk_conv && $past(kind) == k |-> chk_rises == n;
	endproperty
	a_cal_full: assert property (p_cal_len(adc_seq_pkg::cal_full, CAL_FULL_LEN))
		else $error("full calibration length wrong"); // [R6]
	a_cal_dac: assert property (p_cal_len(adc_seq_pkg::cal_dac_fs, CAL_DAC_FS_LEN))
		else $error("dac calibration length wrong"); // [R7]
	a_cal_off: assert property (p_cal_len(adc_seq_pkg::cal_offset, CAL_OFFSET_LEN))
		else $error("offset calibration length wrong"); // [R8]

	property p_byte_switch;
		@(posedge sys_clk) disable iff (rst)
		$rose(hb_lvl) |=> bus_data_out[7:0] == {4'h0, $past(result[11:8])};
	endproperty
	a_byte_switch: assert property (p_byte_switch) else $error("high byte not shown"); // [R9]

	property p_full_pd;
		@(posedge sys_clk) disable iff (rst)
		!busy && ctrl[`CTRL_PWR_HIGH_BIT] && !ctrl[`CTRL_PWR_LOW_BIT] && !$rose(busy)
			|=> full_power_down || busy;
	endproperty
	a_full_pd: assert property (p_full_pd) else $error("full power-down missing"); // [R10]

	property p_write_low;
		@(posedge sys_clk) disable iff (rst)
		wr_take && !hb_lvl |=> ctrl[7:3] == $past(data_s[7:3]);
	endproperty
	a_write_low: assert property (p_write_low) else $error("control write lost"); // [R11]

	c_conv: cover property (@(posedge sys_clk) disable iff (rst) $fell(hold_sample));
	c_cal: cover property (@(posedge sys_clk) disable iff (rst)
		$fell(busy) && !chk_conv);
	c_write: cover property (@(posedge sys_clk) disable iff (rst) wr_take && hb_lvl);
	c_partial: cover property (@(posedge sys_clk) disable iff (rst) $rose(partial_power_down));

endmodule : adc_conv_cal_sequencer

// ==== hw/adc_seq_params.svh ====
// timing counts, control field positions and reset values of the sequencer
// assumes a master clock far slower than sys_clk (at most sys_clk / 6)
// Behaviour
// R1: trigger rising edge puts sampler into hold and starts a conversion.
// R2: a conversion lasts exactly eighteen master clock periods.
// R3: busy rises soon after the trigger and stays high while converting.
// R4: result loads at least half a master period before busy falls.
// R5: busy rises within two and a half master periods of a calibration write.
// R6: full self-calibration lasts 125013 master periods with busy high.
// R7: internal DAC plus system full-scale calibration lasts 111124 master periods.
// R8: system offset calibration lasts 13889 master periods, then busy falls.
// R9: changing high byte select switches the presented byte without a read.
// R10: power high=1, low=0 gives full power-down; both 1 give partial.
// R11: trailing write strobe edge with chip select stores the selected byte.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// *************************************************
// timing counts, in master clock periods
// *************************************************
`define CNT_W              17
`define CONV_CYCLES        17'd18
`define CAL_FULL_CYCLES    17'd125013
`define CAL_DAC_FS_CYCLES  17'd111124
`define CAL_OFFSET_CYCLES  17'd13889

// *************************************************
// control location fields
// *************************************************
`define CTRL_W             12
`define CTRL_RESET         12'h000
`define CTRL_CAL_SEL_LSB   0
`define CTRL_CAL_START_BIT 2
`define CTRL_PWR_LOW_BIT   3
`define CTRL_PWR_HIGH_BIT  4
`define RESULT_RESET       12'h000

`endif

// ==== hw/adc_seq_pkg.sv ====
// types shared by the sequencer files
// assumes adc_seq_params.svh holds the numbers
package adc_seq_pkg;

	typedef enum logic [1:0]
	{
		st_idle = 2'b00,
		st_conv = 2'b01,
		st_cal  = 2'b10
	} seq_state_t;

	typedef enum logic [1:0]
	{
		cal_full   = 2'b00,
		cal_dac_fs = 2'b01,
		cal_offset = 2'b10,
		cal_none   = 2'b11
	} cal_kind_t;

endpackage : adc_seq_pkg

// ==== hw/pin_sync.sv ====
// two-flop synchroniser with edge flags for a group of pins
// assumes pins are asynchronous to sys_clk
`timescale 1ns/10ps

module pin_sync #(
	parameter int           W        = 1,
	parameter logic [W-1:0] IDLE_LVL = '0
)(
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;

	// *************************************************
	// per-bit flops; meta feeds stable only
	// *************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge sys_clk or posedge rst)
			begin
				if (rst)
				begin
					// start at the idle level, so release shows no edge
					meta[i]   <= IDLE_LVL[i];
					stable[i] <= IDLE_LVL[i];
					prev[i]   <= IDLE_LVL[i];
				end
				else
				begin
					meta[i]   <= pin[i];
					stable[i] <= meta[i];
					prev[i]   <= stable[i];
				end
			end
			assign rise[i] = stable[i] & ~prev[i];
			assign fall[i] = ~stable[i] & prev[i];
		end
	endgenerate

	assign level = stable;

endmodule : pin_sync

// ==== sim/host_model.sv ====
// host side: free-running master clock source of the sequencer
// assumes sys_clk runs from time 0; the bench drives bus and trigger pins
`timescale 1ns/10ps

module host_model (
	input  wire logic sys_clk,
	output logic      master_clock_in
);
	logic [2:0] mck_div = 3'h0;

	// master clock = sys_clk / 8, well inside the sync limit of / 6
	// runs free: the sequencer needs it to wake and to count
	always @(posedge sys_clk) mck_div <= #1 mck_div + 3'h1;
	assign master_clock_in = mck_div[2];
endmodule : host_model

// ==== sim/adc_conv_cal_sequencer_bench.sv ====
// self-checking bench of the conversion and calibration sequencer
// assumes host_model gives the master clock; calibration lengths cut to 20/15/10
`timescale 1ns/10ps

module adc_conv_cal_sequencer_bench;
	typedef struct { int len; logic [11:0] data; } exp_t;

	logic        sys_clk = 1'b0;
	logic        rst;
	logic        mck, trg, cs_n, rd_n, wr_n, hbs, busy, hold, oe, fpd, ppd;
	logic [11:0] din, sample_value, dout, last;
	exp_t        exp_q[$];
	exp_t        e;
	int          bad_count, samples_checked, dur, cyc, k;
	int          seed;
	int          cal_len[3] = '{20, 15, 10};

	always #10 sys_clk = ~sys_clk;

	host_model u_host (.sys_clk(sys_clk), .master_clock_in(mck));

	adc_conv_cal_sequencer #(.CAL_FULL_LEN(17'd20), .CAL_DAC_FS_LEN(17'd15),
		.CAL_OFFSET_LEN(17'd10)) u_dut (.sys_clk(sys_clk), .rst(rst),
		.master_clock_in(mck), .conversion_trigger(trg), .chip_select_n(cs_n),
		.read_n(rd_n), .write_n(wr_n), .high_byte_select(hbs), .bus_data_in(din),
		.sample_value(sample_value), .busy(busy), .hold_sample(hold),
		.bus_data_out(dout), .bus_data_oe(oe), .full_power_down(fpd),
		.partial_power_down(ppd));

	task automatic check(input logic ok, input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : check

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task automatic wait_idle();
		for (k = 0; k < 2000 && busy !== 1'b0; k++)
			@(posedge sys_clk);
		cycles(10);
	endtask : wait_idle

	// *****************
	// host bus cycles, pins change 1 ns after an edge
	// *****************
	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cycles

	task automatic wr(input logic hb, input logic [11:0] d);
		cycles(1);
		cs_n = 1'b0;
		hbs = hb;
		din = d;
		cycles(1);
		wr_n = 1'b0;
		cycles(3);
		wr_n = 1'b1;
		cycles(3);
		cs_n = 1'b1;
		hbs = 1'b0;
		// bus driven to the inverse of d: no stale value left on the lines
		din = ~d;
	endtask : wr

	task automatic trig();
		cycles(1);
		trg = 1'b1;
		cycles(6);
		trg = 1'b0;
	endtask : trig

	task automatic rd(input logic on);
		cs_n = !on;
		rd_n = !on;
	endtask : rd

	task automatic view(input logic hb);
		hbs = hb;
	endtask : view

	// *****************
	// watcher: busy length in sys_clk cycles, master period is 8
	// *****************
	always @(posedge sys_clk)
	begin
		#2;
		if (busy === 1'b1)
			dur = dur + 1;
		else if (dur != 0)
		begin
			e = exp_q.pop_front();
			check(dur >= (e.len - 1) * 8 && dur <= e.len * 8 + 2, dur, e.len * 8);
			check(dout === e.data, dout, e.data);
			dur = 0;
		end
	end

	// hang guard, far above the thousand or so cycles needed
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			stop_test();
		end
	end

	// *****************
	// main sequence
	// *****************
	initial
	begin
		seed = 32'hb8444fe3;
		rst = 1'b1;
		sample_value = 12'h000;
		trg = 1'b0;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		hbs = 1'b0;
		din = 12'h000;
		repeat (4) @(posedge sys_clk);
		#1 rst = 1'b0;
		cycles(2);
		// idle-high strobes must not look selected while the syncs fill
		check(oe === 1'b0 && busy === 1'b0, oe, 0);
		cycles(2);
		for (int i = 0; i < 3; i++)
		begin
			last = 12'($random(seed));
			sample_value = last;
			exp_q.push_back('{18, last});
			trig();
			check(busy === 1'b1 && hold === 1'b1, busy, 1);
			if (i == 1)
			begin
				// retrigger mid-conversion must not stretch or restart it
				cycles(60);
				trig();
			end
			wait_idle();
		end
		view(1'b1);
		cycles(5);
		check(dout === {last[11:8], 4'h0, last[11:8]}, dout, last);
		view(1'b0);
		cycles(5);
		check(dout === last, dout, last);
		rd(1'b1);
		cycles(5);
		check(oe === 1'b1, oe, 1);
		rd(1'b0);
		cycles(5);
		check(oe === 1'b0, oe, 0);
		for (int s = 0; s < 3; s++)
		begin
			exp_q.push_back('{cal_len[s], last});
			wr(1'b0, {9'h000, 1'b1, 2'(s)});
			cycles(2);
			check(busy === 1'b1, busy, 1);
			wait_idle();
		end
		// select code 11 is not a calibration
		wr(1'b0, 12'h007);
		cycles(3);
		check(busy === 1'b0, busy, 0);
		for (int p = 0; p < 4; p++)
		begin
			wr(1'b0, {7'h00, 2'(p), 3'h0});
			wr(1'b1, 12'($random(seed)));
			cycles(3);
			check(fpd === (p == 2), fpd, p);
			check(ppd === (p == 3), ppd, p);
		end
		check(exp_q.size() == 0, exp_q.size(), 0);
		stop_test();
	end
endmodule : adc_conv_cal_sequencer_bench
